// ===== hw/srs_top.sv
// status register sets: device state and standard operation
`timescale 1ns/10ps
module srs_top
  import srs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [1:0] cmd_arg_kind,
  input wire logic [15:0] cmd_arg_value,
  input wire logic [14:0] ds_cond,
  input wire logic [14:0] so_cond,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic cmd_error,
  output logic ds_summary,
  output logic so_summary
);
  logic [14:0] ds_en_ff;
  logic [14:0] ds_rise_ff;
  logic [14:0] ds_fall_ff;
  logic [14:0] so_en_ff;
  logic [14:0] so_rise_ff;
  logic [14:0] so_fall_ff;
  logic [14:0] nxt_ds_en;
  logic [14:0] nxt_ds_rise;
  logic [14:0] nxt_ds_fall;
  logic [14:0] nxt_so_en;
  logic [14:0] nxt_so_rise;
  logic [14:0] nxt_so_fall;
  logic rsp_valid_ff;
  logic [15:0] rsp_data_ff;
  logic cmd_error_ff;
  logic ds_sum_ff;
  logic so_sum_ff;
  logic nxt_rsp_valid;
  logic [15:0] nxt_rsp_data;
  logic nxt_cmd_error;
  logic nxt_ds_sum;
  logic nxt_so_sum;
  logic [14:0] wr_mask;
  logic wr_legal;
  logic [14:0] ds_evt;
  logic [14:0] ds_set;
  logic [14:0] so_evt;
  logic [14:0] so_set;
  logic ds_evt_clr;
  logic so_evt_clr;

  // true when the command is one of the queries
  function automatic logic is_query(input logic [3:0] code);
    case (code)
      CMD_DS_COND_Q, CMD_DS_EN_Q, CMD_DS_EVT_Q, CMD_DS_FALL_Q,
      CMD_DS_RISE_Q, CMD_SO_COND_Q, CMD_SO_EVT_Q: is_query = 1'b1;
      default: is_query = 1'b0;
    endcase
  endfunction

  // true when the command writes a mask register
  function automatic logic is_write(input logic [3:0] code);
    case (code)
      CMD_DS_EN_W, CMD_DS_FALL_W, CMD_DS_RISE_W: is_write = 1'b1;
      default: is_write = 1'b0;
    endcase
  endfunction

  // number or bound keyword to mask
  srs_value_decode u_decode (
    .arg_kind(cmd_arg_kind),
    .arg_value(cmd_arg_value),
    .mask(wr_mask),
    .legal(wr_legal)
  );

  // device event cleared by its query
  assign ds_evt_clr = cmd_valid && (cmd_code == CMD_DS_EVT_Q);
  // operation event cleared by its query
  assign so_evt_clr = cmd_valid && (cmd_code == CMD_SO_EVT_Q);

  srs_event_set u_ds_events (
    .clk(clk),
    .arst_n(arst_n),
    .cond(ds_cond),
    .rise_mask(ds_rise_ff),
    .fall_mask(ds_fall_ff),
    .clear(ds_evt_clr),
    .event_bits(ds_evt),
    .event_set(ds_set)
  );

  srs_event_set u_so_events (
    .clk(clk),
    .arst_n(arst_n),
    .cond(so_cond),
    .rise_mask(so_rise_ff),
    .fall_mask(so_fall_ff),
    .clear(so_evt_clr),
    .event_bits(so_evt),
    .event_set(so_set)
  );

  // mask registers: writes, status preset; instrument preset touches none
  always_comb begin
    nxt_ds_en = ds_en_ff;
    nxt_ds_rise = ds_rise_ff;
    nxt_ds_fall = ds_fall_ff;
    nxt_so_en = so_en_ff;
    nxt_so_rise = so_rise_ff;
    nxt_so_fall = so_fall_ff;
    if (cmd_valid) begin
      case (cmd_code)
        CMD_DS_EN_W: begin
          if (wr_legal) begin
            nxt_ds_en = wr_mask;
          end
        end
        CMD_DS_FALL_W: begin
          if (wr_legal) begin
            nxt_ds_fall = wr_mask;
          end
        end
        CMD_DS_RISE_W: begin
          if (wr_legal) begin
            nxt_ds_rise = wr_mask;
          end
        end
        CMD_STAT_PRESET: begin
          nxt_ds_en = RST_ENABLE;
          nxt_ds_rise = RST_RISE;
          nxt_ds_fall = RST_FALL;
          nxt_so_en = RST_ENABLE;
          nxt_so_rise = RST_RISE;
          nxt_so_fall = RST_FALL;
        end
        CMD_INSTR_PRESET: begin
          nxt_ds_en = ds_en_ff;
        end
        default: begin
          nxt_ds_en = ds_en_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ds_en_ff <= RST_ENABLE;
      ds_rise_ff <= RST_RISE;
      ds_fall_ff <= RST_FALL;
      so_en_ff <= RST_ENABLE;
      so_rise_ff <= RST_RISE;
      so_fall_ff <= RST_FALL;
    end else begin
      ds_en_ff <= nxt_ds_en;
      ds_rise_ff <= nxt_ds_rise;
      ds_fall_ff <= nxt_ds_fall;
      so_en_ff <= nxt_so_en;
      so_rise_ff <= nxt_so_rise;
      so_fall_ff <= nxt_so_fall;
    end
  end

  // answer path: one cycle after the query, the value as its weight sum
  always_comb begin
    nxt_rsp_valid = cmd_valid && is_query(cmd_code);
    nxt_cmd_error = 1'b0;
    nxt_rsp_data = rsp_data_ff;
    if (cmd_valid) begin
      case (cmd_code)
        CMD_DS_COND_Q: nxt_rsp_data = {RSP_TOP_BIT, ds_cond};
        CMD_DS_EN_Q: nxt_rsp_data = {RSP_TOP_BIT, ds_en_ff};
        CMD_DS_EVT_Q: nxt_rsp_data = {RSP_TOP_BIT, ds_evt};
        CMD_DS_FALL_Q: nxt_rsp_data = {RSP_TOP_BIT, ds_fall_ff};
        CMD_DS_RISE_Q: nxt_rsp_data = {RSP_TOP_BIT, ds_rise_ff};
        CMD_SO_COND_Q: nxt_rsp_data = {RSP_TOP_BIT, so_cond};
        CMD_SO_EVT_Q: nxt_rsp_data = {RSP_TOP_BIT, so_evt};
        default: nxt_rsp_data = rsp_data_ff;
      endcase
      // out of range numbers and unknown codes are refused
      if (is_write(cmd_code) && !wr_legal) begin
        nxt_cmd_error = 1'b1;
      end else if (!is_write(cmd_code) && !is_query(cmd_code)
                   && cmd_code != CMD_STAT_PRESET
                   && cmd_code != CMD_INSTR_PRESET) begin
        nxt_cmd_error = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 16'h0000;
      cmd_error_ff <= 1'b0;
      ds_sum_ff <= 1'b0;
      so_sum_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff <= nxt_rsp_data;
      cmd_error_ff <= nxt_cmd_error;
      ds_sum_ff <= nxt_ds_sum;
      so_sum_ff <= nxt_so_sum;
    end
  end

  // summary of enabled events
  // registered, so the summary lags the event bits by one cycle
  always_comb begin
    nxt_ds_sum = |(ds_evt & ds_en_ff);
    nxt_so_sum = |(so_evt & so_en_ff);
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign cmd_error = cmd_error_ff;
  assign ds_summary = ds_sum_ff;
  assign so_summary = so_sum_ff;

  // checks on the behaviour above
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_ds_evt_query;
    cmd_valid && cmd_code == CMD_DS_EVT_Q;
  endsequence

  sequence s_so_evt_query;
    cmd_valid && cmd_code == CMD_SO_EVT_Q;
  endsequence

  sequence s_legal_write(logic [3:0] code);
    cmd_valid && cmd_code == code && wr_legal;
  endsequence

  a_ds_evt_clear: assert property (
    s_ds_evt_query |=> rsp_valid && rsp_data[14:0] == $past(ds_evt)
                       && ds_evt == $past(ds_set))
    else $error("device event not returned or not cleared");

  a_so_evt_clear: assert property (
    s_so_evt_query |=> rsp_valid && rsp_data[14:0] == $past(so_evt)
                       && so_evt == $past(so_set))
    else $error("operation event not returned or not cleared");

  a_en_write_query: assert property (
    s_legal_write(CMD_DS_EN_W) ##1 (cmd_valid && cmd_code == CMD_DS_EN_Q)
    |=> rsp_data[14:0] == $past(wr_mask, 2))
    else $error("enable mask readback differs from write");

  a_rise_write: assert property (
    s_legal_write(CMD_DS_RISE_W) |=> ds_rise_ff == $past(wr_mask))
    else $error("rising filter not loaded");

  a_fall_write: assert property (
    s_legal_write(CMD_DS_FALL_W) |=> ds_fall_ff == $past(wr_mask))
    else $error("falling filter not loaded");

  a_max_bound: assert property (
    cmd_valid && cmd_code == CMD_DS_EN_W && cmd_arg_kind == ARG_MAX
    |=> ds_en_ff == MASK_MAX)
    else $error("MAX did not set every bit");

  a_instr_preset_keep: assert property (
    cmd_valid && cmd_code == CMD_INSTR_PRESET
    |=> $stable(ds_en_ff) && $stable(ds_rise_ff) && $stable(ds_fall_ff))
    else $error("instrument preset changed a mask");

  a_stat_preset: assert property (
    cmd_valid && cmd_code == CMD_STAT_PRESET
    |=> ds_en_ff == RST_ENABLE && so_en_ff == RST_ENABLE
        && ds_rise_ff == RST_RISE && ds_fall_ff == RST_FALL
        && so_rise_ff == RST_RISE && so_fall_ff == RST_FALL)
    else $error("status preset values wrong");

  a_cond_query: assert property (
    cmd_valid && cmd_code == CMD_DS_COND_Q
    |=> rsp_valid && rsp_data == {RSP_TOP_BIT, $past(ds_cond)})
    else $error("device condition answer wrong");

  a_so_cond_query: assert property (
    cmd_valid && cmd_code == CMD_SO_COND_Q
    |=> rsp_valid && rsp_data[14:0] == $past(so_cond))
    else $error("operation condition answer wrong");

  a_top_bit_zero: assert property (
    rsp_valid |-> rsp_data[15] == 1'b0)
    else $error("answer carries a bit above 14");

  a_range_refuse: assert property (
    cmd_valid && cmd_code == CMD_DS_EN_W && !wr_legal
    |=> cmd_error && $stable(ds_en_ff) && !rsp_valid)
    else $error("out of range write not refused");

  a_summary: assert property (
    ##1 ds_summary == $past(|(ds_evt & ds_en_ff)))
    else $error("device summary mismatch");

  a_rise_latch: assert property (
    ds_set != RST_EVENT |=> (ds_evt & $past(ds_set)) == $past(ds_set))
    else $error("filtered edge not latched");
endmodule

// ===== hw/srs_pkg.sv
// constants, command codes and reset values of the status register sets
// Operation
// - registers hold bits 0 to 14 only, each weighted two to its position
// - a write value is the sum of weights; exactly those bits become one
// - every query returns the summed weights of the set bits
// - device enable mask takes 0 to 32767, MAX or MIN; query returns mask
// - device event query returns set bits, then clears that register
// - device condition query reports condition bits set at query time
// - device falling filter takes 0 to 32767, MAX or MIN; readable
// - device rising filter takes 0 to 32767, MAX or MIN; readable
// - instrument preset leaves enable and both filter masks untouched
// - operation condition query returns summed weights of its set bits
// - operation event query returns set bits, then clears that register
// - status preset clears enables, sets rising filters, clears falling filters
package srs_pkg;
  localparam int REG_W = 15;
  localparam int CMD_W = 4;
  localparam int VAL_W = 16;
  // command codes on the command port
  localparam logic [3:0] CMD_DS_COND_Q = 4'h0;
  localparam logic [3:0] CMD_DS_EN_W = 4'h1;
  localparam logic [3:0] CMD_DS_EN_Q = 4'h2;
  localparam logic [3:0] CMD_DS_EVT_Q = 4'h3;
  localparam logic [3:0] CMD_DS_FALL_W = 4'h4;
  localparam logic [3:0] CMD_DS_FALL_Q = 4'h5;
  localparam logic [3:0] CMD_DS_RISE_W = 4'h6;
  localparam logic [3:0] CMD_DS_RISE_Q = 4'h7;
  localparam logic [3:0] CMD_SO_COND_Q = 4'h8;
  localparam logic [3:0] CMD_SO_EVT_Q = 4'h9;
  localparam logic [3:0] CMD_STAT_PRESET = 4'hA;
  localparam logic [3:0] CMD_INSTR_PRESET = 4'hB;
  // argument kinds of a write
  localparam logic [1:0] ARG_NUMBER = 2'h0;
  localparam logic [1:0] ARG_MAX = 2'h1;
  localparam logic [1:0] ARG_MIN = 2'h2;
  // legal range of a written number
  localparam logic [15:0] VAL_MAX = 16'h7FFF;
  localparam logic [14:0] MASK_MAX = 15'h7FFF;
  localparam logic [14:0] MASK_MIN = 15'h0000;
  // reset values; the enable and filter ones equal the status preset values
  localparam logic [14:0] RST_ENABLE = 15'h0000;
  localparam logic [14:0] RST_RISE = 15'h7FFF;
  localparam logic [14:0] RST_FALL = 15'h0000;
  localparam logic [14:0] RST_EVENT = 15'h0000;
  // answer layout: bit 15 is never a register bit
  localparam logic RSP_TOP_BIT = 1'b0;
endpackage

// ===== hw/srs_value_decode.sv
// turns a written number or bound keyword into a register mask
`timescale 1ns/10ps
module srs_value_decode
  import srs_pkg::*;
(
  input wire logic [1:0] arg_kind,
  input wire logic [15:0] arg_value,
  output logic [14:0] mask,
  output logic legal
);
  // bounds map to the extremes, numbers are range checked
  always_comb begin
    mask = MASK_MIN;
    legal = 1'b0;
    case (arg_kind)
      ARG_MAX: begin
        mask = MASK_MAX;
        legal = 1'b1;
      end
      ARG_MIN: begin
        mask = MASK_MIN;
        legal = 1'b1;
      end
      ARG_NUMBER: begin
        // summed weights land bit for bit; bit 15 cannot exist
        mask = arg_value[14:0];
        legal = (arg_value <= VAL_MAX);
      end
      default: begin
        mask = MASK_MIN;
        legal = 1'b0;
      end
    endcase
  end
endmodule

// ===== hw/srs_event_set.sv
// transition filters and sticky event bits of one register set
`timescale 1ns/10ps
module srs_event_set
  import srs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [14:0] cond,
  input wire logic [14:0] rise_mask,
  input wire logic [14:0] fall_mask,
  input wire logic clear,
  output logic [14:0] event_bits,
  output logic [14:0] event_set
);
  logic [14:0] cond_ff;
  logic [14:0] event_ff;
  logic [14:0] nxt_event;

  genvar i;
  // one edge detector per bit
  generate
    for (i = 0; i < REG_W; i++) begin : g_bit
      assign event_set[i] = (cond[i] & ~cond_ff[i] & rise_mask[i])
                          | (~cond[i] & cond_ff[i] & fall_mask[i]);
    end
  endgenerate

  // a new edge wins over the read clear so nothing is lost
  always_comb begin
    nxt_event = (clear ? RST_EVENT : event_ff) | event_set;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cond_ff <= RST_EVENT;
      event_ff <= RST_EVENT;
    end else begin
      cond_ff <= cond;
      event_ff <= nxt_event;
    end
  end

  assign event_bits = event_ff;
endmodule

// ===== verif/srs_host_model.sv
// controller model: issues status commands and collects the answers
`timescale 1ns/10ps
module srs_host_model
  import srs_pkg::*;
(
  input wire logic clk,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic cmd_error,
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic [1:0] cmd_arg_kind,
  output logic [15:0] cmd_arg_value
);
  // quiet bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 4'h0;
    cmd_arg_kind = ARG_NUMBER;
    cmd_arg_value = 16'h0000;
  end
  // entered at a falling edge; strobe may stay high for a back-to-back command
  // writes carry the weight sum
  task automatic issue(input logic [3:0] code, input logic [1:0] kind,
                       input logic [15:0] value, output logic [15:0] data,
                       output logic got, output logic err);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_arg_kind = kind;
    cmd_arg_value = value;
    @(negedge clk);
    data = rsp_data;
    got = rsp_valid;
    err = cmd_error;
  endtask
  // code and value fields are scrambled while idle so a stale value never passes for a command
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_code = ~cmd_code;
    cmd_arg_value = ~cmd_arg_value;
    @(negedge clk);
  endtask
endmodule

// ===== verif/srs_top_tb_top.sv
// self-checking bench of the status register sets
`timescale 1ns/10ps
module srs_top_tb_top
  import srs_pkg::*;
;
  logic clk, arst_n, cmd_valid, rsp_valid, cmd_error, ds_summary, so_summary;
  logic [3:0] cmd_code;
  logic [1:0] cmd_arg_kind;
  logic [15:0] cmd_arg_value, rsp_data;
  logic [14:0] ds_cond, so_cond;
  int fails, check_count, cycles;

  srs_top srs_top_i (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_arg_kind(cmd_arg_kind), .cmd_arg_value(cmd_arg_value),
    .ds_cond(ds_cond), .so_cond(so_cond), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .cmd_error(cmd_error), .ds_summary(ds_summary), .so_summary(so_summary));
  srs_host_model srs_host_model_i (.clk(clk), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .cmd_error(cmd_error), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_arg_kind(cmd_arg_kind), .cmd_arg_value(cmd_arg_value));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard: the whole sequence needs about a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("[ERR] %0t run too long", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  // query with strobe and value check
  task automatic q_chk(input logic [3:0] code, input logic [15:0] exp);
    logic [15:0] d;
    logic g, e;
    srs_host_model_i.issue(code, ARG_NUMBER, 16'h0000, d, g, e);
    check({15'h0000, g}, 16'h0001, "answer strobe");
    check(d, exp, "answer value");
  endtask
  // write or preset: no answer, refusal flag as expected
  task automatic w_chk(input logic [3:0] code, input logic [1:0] kind,
                       input logic [15:0] val, input logic exp_err);
    logic [15:0] d;
    logic g, e;
    srs_host_model_i.issue(code, kind, val, d, g, e);
    check({15'h0000, g}, 16'h0000, "stray answer");
    check({15'h0000, e}, {15'h0000, exp_err}, "refusal flag");
  endtask
  // read-clear an event register without judging it
  task automatic flush(input logic [3:0] code);
    logic [15:0] d;
    logic g, e;
    srs_host_model_i.issue(code, ARG_NUMBER, 16'h0000, d, g, e);
  endtask

  task automatic t_reset();
    q_chk(CMD_DS_EN_Q, 16'h0000);
    q_chk(CMD_DS_RISE_Q, 16'h7FFF);
    q_chk(CMD_DS_FALL_Q, 16'h0000);
    q_chk(CMD_DS_EVT_Q, 16'h0000);
    srs_host_model_i.idle();
    check({15'h0000, ds_summary}, 16'h0000, "device summary");
    $display("test reset values done");
  endtask
  // write codes sit one below their query codes
  task automatic t_masks();
    logic [3:0] wr [3];
    wr = '{CMD_DS_EN_W, CMD_DS_FALL_W, CMD_DS_RISE_W};
    for (int i = 0; i < 3; i++) begin
      w_chk(wr[i], ARG_NUMBER, 16'h0004, 1'b0);
      q_chk(wr[i] + 4'h1, 16'h0004);
      w_chk(wr[i], ARG_NUMBER, 16'h8000, 1'b1);
      w_chk(wr[i], 2'h3, 16'h0001, 1'b1);
      q_chk(wr[i] + 4'h1, 16'h0004);
      w_chk(wr[i], ARG_MAX, 16'h0000, 1'b0);
      q_chk(wr[i] + 4'h1, 16'h7FFF);
      w_chk(wr[i], ARG_MIN, 16'h1111, 1'b0);
      q_chk(wr[i] + 4'h1, 16'h0000);
      w_chk(wr[i], ARG_NUMBER, 16'h7FFF, 1'b0);
      w_chk(wr[i], ARG_NUMBER, 16'h4A51, 1'b0);
      q_chk(wr[i] + 4'h1, 16'h4A51);
    end
    srs_host_model_i.idle();
    $display("test mask writes done");
  endtask
  task automatic t_cond();
    ds_cond = 15'h1234;
    so_cond = 15'h4321;
    q_chk(CMD_DS_COND_Q, 16'h1234);
    q_chk(CMD_SO_COND_Q, 16'h4321);
    ds_cond = 15'h0421;
    q_chk(CMD_DS_COND_Q, 16'h0421);
    ds_cond = 15'h0000;
    so_cond = 15'h0000;
    srs_host_model_i.idle();
    $display("test conditions done");
  endtask
  // bit 0 rise-filtered, bit 1 fall-filtered, bit 2 filtered out
  task automatic t_events();
    w_chk(CMD_DS_RISE_W, ARG_NUMBER, 16'h0001, 1'b0);
    w_chk(CMD_DS_FALL_W, ARG_NUMBER, 16'h0002, 1'b0);
    w_chk(CMD_DS_EN_W, ARG_NUMBER, 16'h0003, 1'b0);
    flush(CMD_DS_EVT_Q);
    ds_cond = 15'h0007;
    repeat (4) srs_host_model_i.idle();
    check({15'h0000, ds_summary}, 16'h0001, "summary raised");
    q_chk(CMD_DS_EVT_Q, 16'h0001);
    repeat (3) srs_host_model_i.idle();
    check({15'h0000, ds_summary}, 16'h0000, "summary dropped");
    q_chk(CMD_DS_EVT_Q, 16'h0000);
    ds_cond = 15'h0000;
    repeat (4) srs_host_model_i.idle();
    q_chk(CMD_DS_EVT_Q, 16'h0002);
    srs_host_model_i.idle();
    $display("test device events done");
  endtask
  // operation enable stays zero, so its summary must stay low
  task automatic t_so();
    flush(CMD_SO_EVT_Q);
    so_cond = 15'h0010;
    repeat (4) srs_host_model_i.idle();
    check({15'h0000, so_summary}, 16'h0000, "operation summary");
    q_chk(CMD_SO_EVT_Q, 16'h0010);
    q_chk(CMD_SO_EVT_Q, 16'h0000);
    srs_host_model_i.idle();
    $display("test operation events done");
  endtask
  task automatic t_presets();
    w_chk(CMD_DS_EN_W, ARG_NUMBER, 16'h0005, 1'b0);
    w_chk(CMD_DS_RISE_W, ARG_NUMBER, 16'h0006, 1'b0);
    w_chk(CMD_DS_FALL_W, ARG_NUMBER, 16'h0007, 1'b0);
    w_chk(CMD_INSTR_PRESET, ARG_NUMBER, 16'h0000, 1'b0);
    q_chk(CMD_DS_EN_Q, 16'h0005);
    q_chk(CMD_DS_RISE_Q, 16'h0006);
    q_chk(CMD_DS_FALL_Q, 16'h0007);
    w_chk(CMD_STAT_PRESET, ARG_NUMBER, 16'h0000, 1'b0);
    q_chk(CMD_DS_EN_Q, 16'h0000);
    q_chk(CMD_DS_RISE_Q, 16'h7FFF);
    q_chk(CMD_DS_FALL_Q, 16'h0000);
    w_chk(4'hC, ARG_NUMBER, 16'h0000, 1'b1);
    srs_host_model_i.idle();
    $display("test presets done");
  endtask
  // mid-run reset: masks back to defaults, a condition high at release raises an event
  task automatic t_rst_again();
    w_chk(CMD_DS_RISE_W, ARG_NUMBER, 16'h0000, 1'b0);
    w_chk(CMD_DS_EN_W, ARG_NUMBER, 16'h0009, 1'b0);
    srs_host_model_i.idle();
    arst_n = 1'b0;
    ds_cond = 15'h0008;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    q_chk(CMD_DS_EN_Q, 16'h0000);
    q_chk(CMD_DS_RISE_Q, 16'h7FFF);
    q_chk(CMD_DS_EVT_Q, 16'h0008);
    q_chk(CMD_SO_EVT_Q, 16'h0010);
    ds_cond = 15'h0000;
    srs_host_model_i.idle();
    check({15'h0000, ds_summary}, 16'h0000, "summary after reset");
    $display("test second reset done");
  endtask

  // reset for ten cycles, then the scenarios in turn
  initial begin
    fails = 0;
    check_count = 0;
    cycles = 0;
    arst_n = 1'b0;
    ds_cond = 15'h0000;
    so_cond = 15'h0000;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    srs_host_model_i.idle();
    t_reset();
    t_masks();
    t_cond();
    t_events();
    t_so();
    t_presets();
    t_rst_again();
    tally_and_finish();
  end
endmodule
